//--- hdl/ddc_pkg.sv
// package: constants and types of the ddr2 command interface block
package ddc_pkg;

  // ---------------------------------------------------------------
  // widths and array shape
  // ---------------------------------------------------------------
  localparam int DQ_W      = 8;   // x8 data pins
  localparam int A_W       = 14;  // row address width on x8
  localparam int NBANK     = 4;
  localparam int MCOL_W    = 4;   // column words kept per bank: 16
  localparam int PIN_W     = 32;  // synchronised pin vector

  // ---------------------------------------------------------------
  // positions in the synchronised pin vector
  // ---------------------------------------------------------------
  localparam int P_DQ      = 0;   // 8 bits
  localparam int P_DQS     = 8;
  localparam int P_DM      = 9;
  localparam int P_ODT     = 10;
  localparam int P_A       = 11;  // 14 bits
  localparam int P_AP      = 21;  // address bit 10
  localparam int P_BA      = 25;  // 2 bits
  localparam int P_WE      = 27;  // {ras,cas,we} from here
  localparam int P_CS      = 30;
  localparam int P_CKE     = 31;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CFG  = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_ROW0 = 12'h010;  // 0x10..0x1c, one per bank

  // configuration fields
  localparam int CFG_W     = 11;
  localparam int CF_BL8    = 0;
  localparam int CF_BT     = 1;   // 1: interleaved order
  localparam int CF_CL     = 2;   // 3 bits
  localparam int CF_AL     = 5;   // 3 bits
  localparam int CF_ODTOFF = 8;
  localparam int CF_DRVRED = 9;
  localparam int CF_X16    = 10;
  localparam logic [CFG_W-1:0] CFG_RST = 11'h00c;  // bl4, cl 3, al 0

  // status fields
  localparam int ST_OPEN   = 0;   // 4 bits
  localparam int ST_PWR    = 4;   // 2 bits
  localparam int ST_LOCK   = 6;
  localparam int ST_BUSY   = 7;
  localparam int ST_REF    = 16;  // 16 bits

  // latency limits and mode register selects
  localparam logic [2:0] CL_MIN   = 3'h3;
  localparam logic [2:0] CL_MAX   = 3'h6;
  localparam logic [2:0] AL_MAX   = 3'h5;
  localparam logic [1:0] MR_SEL   = 2'h0;
  localparam logic [1:0] EMR1_SEL = 2'h1;

  // rising crossings the delay loop needs before it reports lock
  localparam logic [4:0] DLL_LOCK_RISES = 5'h10;

  typedef enum logic [2:0] {
    CMD_MRS  = 3'b000,
    CMD_REF  = 3'b001,
    CMD_PRE  = 3'b010,
    CMD_ACT  = 3'b011,
    CMD_WR   = 3'b100,
    CMD_RD   = 3'b101,
    CMD_RSVD = 3'b110,
    CMD_NOP  = 3'b111
  } ddc_cmd_t;

  typedef enum logic [1:0] {
    PWR_ON  = 2'b00,
    PWR_PPD = 2'b01,
    PWR_APD = 2'b10,
    PWR_SR  = 2'b11
  } ddc_pwr_t;

  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_WAIT = 2'b01,
    BST_RD   = 2'b10,
    BST_WR   = 2'b11
  } ddc_bst_t;

endpackage

//--- hdl/ddc_link_if.sv
// interface: synchronised link pins and clock crossing pulses
`timescale 1ns/10ps
interface ddc_link_if;
  logic [ddc_pkg::PIN_W-1:0] pins;
  logic                      rise;
  logic                      fall;
  modport src (output pins, output rise, output fall);
  modport dst (input pins, input rise, input fall);
endinterface

//--- hdl/ddc_link_sync.sv
// module: pin synchronisers and link clock crossing detector
`timescale 1ns/10ps
module ddc_link_sync (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [ddc_pkg::PIN_W-1:0] raw_pins,
  input  wire logic                      ck,
  input  wire logic                      ck_n,
  ddc_link_if.src                        lk
);

  logic [ddc_pkg::PIN_W+1:0] s1_q;
  logic [ddc_pkg::PIN_W+1:0] s2_q;
  logic                      diff_q;
  logic                      diff;

  // ---------------------------------------------------------------
  // two flops on every pin, clock pair included
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {ck_n, ck, raw_pins};
      s2_q <= s1_q;
    end
  end

  // true clock high and complement low marks the positive crossing
  assign diff = s2_q[ddc_pkg::PIN_W] & ~s2_q[ddc_pkg::PIN_W+1];

  // previous crossing level, for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      diff_q <= 1'b0;
    end else begin
      diff_q <= diff;
    end
  end

  // pins and clock share the same delay, so they stay aligned
  assign lk.pins = s2_q[ddc_pkg::PIN_W-1:0];
  assign lk.rise = diff & ~diff_q;
  assign lk.fall = ~diff & diff_q;

endmodule

//--- hdl/ddc_top.sv
// module: device side command, address, power and burst logic
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps

module ddc_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // memory link pins
  input  wire logic        ck,
  input  wire logic        ck_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bank_select_lines,
  input  wire logic [13:0] addr,
  input  wire logic        termination_enable,
  input  wire logic        write_byte_mask,
  input  wire logic        dqs_in,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_n,
  output logic             dqs_out,
  output logic             dqs_oe_n,
  output logic             term_on,
  output logic             drive_reduced
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // clamp latency fields into the supported ranges
  function automatic logic [ddc_pkg::CFG_W-1:0] cfg_fix(input logic [ddc_pkg::CFG_W-1:0] c);
    logic [ddc_pkg::CFG_W-1:0] r;
    r = c;
    if (c[ddc_pkg::CF_CL+:3] < ddc_pkg::CL_MIN) begin
      r[ddc_pkg::CF_CL+:3] = ddc_pkg::CL_MIN;
    end else if (c[ddc_pkg::CF_CL+:3] > ddc_pkg::CL_MAX) begin
      r[ddc_pkg::CF_CL+:3] = ddc_pkg::CL_MAX;
    end
    if (c[ddc_pkg::CF_AL+:3] > ddc_pkg::AL_MAX) begin
      r[ddc_pkg::CF_AL+:3] = ddc_pkg::AL_MAX;
    end
    return r;
  endfunction

  // word of a burst: wraps inside the burst, sequential or interleaved
  function automatic logic [ddc_pkg::MCOL_W-1:0] bidx(input logic [3:0] col, input logic [2:0] beat,
                                                     input logic bl8, input logic bt);
    logic [2:0] msk;
    logic [2:0] off;
    msk = bl8 ? 3'h7 : 3'h3;
    off = bt ? (col[2:0] ^ beat) : (col[2:0] + beat);
    return {col[3], (col[2:0] & ~msk) | (off & msk)};
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ddc_link_if lk ();

  logic [ddc_pkg::CFG_W-1:0] cfg_q;
  logic [ddc_pkg::NBANK-1:0] open_q;
  logic [ddc_pkg::A_W-1:0]   row_q [ddc_pkg::NBANK];
  logic [7:0]                mem_q [ddc_pkg::NBANK * 16];
  logic [7:0]                pf_q  [8];
  ddc_pkg::ddc_pwr_t         pwr_q;
  ddc_pkg::ddc_bst_t         bst_q;
  logic [3:0]                lat_q;
  logic [2:0]                beat_q;
  logic [1:0]                bank_q;
  logic [3:0]                col_q;
  logic                      ap_q;
  logic                      wr_q;
  logic [4:0]                lock_q;
  logic [15:0]               ref_q;
  logic                      dqs_q;
  logic                      wr_pend_q;
  logic [11:0]               wr_addr_q;
  logic [31:0]               rd_v;

  ddc_pkg::ddc_cmd_t         cmd;
  logic                      s_cke;
  logic [1:0]                s_ba;
  logic [ddc_pkg::A_W-1:0]   s_a;
  logic                      cmd_ok;
  logic                      col_cmd;
  logic [3:0]                rl;
  logic [2:0]                blast;
  logic                      rd_start;
  logic                      rd_step;
  logic                      wr_step;
  logic                      bst_end;

  ddc_link_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .raw_pins ({cke, cs_n, ras_n, cas_n, we_n, bank_select_lines, addr,
                termination_enable, write_byte_mask, dqs_in, dq_in}),
    .ck       (ck),
    .ck_n     (ck_n),
    .lk       (lk.src)
  );

  // ---------------------------------------------------------------
  // command decode at positive crossings
  // ---------------------------------------------------------------
  assign cmd     = ddc_pkg::ddc_cmd_t'(lk.pins[ddc_pkg::P_WE+:3]);
  assign s_cke   = lk.pins[ddc_pkg::P_CKE];
  assign s_ba    = lk.pins[ddc_pkg::P_BA+:2];
  assign s_a     = lk.pins[ddc_pkg::P_A+:ddc_pkg::A_W];
  // buffers only listen while powered up and enable is high
  assign cmd_ok  = lk.rise & (pwr_q == ddc_pkg::PWR_ON) & s_cke
                   & ~lk.pins[ddc_pkg::P_CS];
  // a column command to a closed bank is dropped
  assign col_cmd = cmd_ok & ((cmd == ddc_pkg::CMD_RD) | (cmd == ddc_pkg::CMD_WR))
                   & open_q[s_ba];

  // read latency is posted plus column latency
  assign rl = {1'b0, cfg_q[ddc_pkg::CF_AL+:3]} + {1'b0, cfg_q[ddc_pkg::CF_CL+:3]};
  assign blast = cfg_q[ddc_pkg::CF_BL8] ? 3'h7 : 3'h3;

  assign rd_start = (bst_q == ddc_pkg::BST_WAIT) & lk.rise & (lat_q == 4'h1) & ~wr_q;
  assign rd_step  = (bst_q == ddc_pkg::BST_RD) & (lk.rise | lk.fall);
  // write words are taken on each strobe transition
  assign wr_step  = (bst_q == ddc_pkg::BST_WR) & (lk.pins[ddc_pkg::P_DQS] ^ dqs_q);
  assign bst_end  = (rd_step | wr_step) & (beat_q == blast);

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states, always okay
  // ---------------------------------------------------------------

  // register read mux; unmapped addresses read zero
  always_comb begin
    rd_v = 32'h0000_0000;
    if (haddr[31:12] == 20'h00000) begin
      if (haddr[11:0] == ddc_pkg::REG_CFG) begin
        rd_v[ddc_pkg::CFG_W-1:0] = cfg_q;
      end else if (haddr[11:0] == ddc_pkg::REG_STAT) begin
        rd_v[ddc_pkg::ST_OPEN+:4] = open_q;
        rd_v[ddc_pkg::ST_PWR+:2]  = pwr_q;
        rd_v[ddc_pkg::ST_LOCK]    = (lock_q == ddc_pkg::DLL_LOCK_RISES);
        rd_v[ddc_pkg::ST_BUSY]    = (bst_q != ddc_pkg::BST_IDLE);
        rd_v[ddc_pkg::ST_REF+:16] = ref_q;
      end else if (haddr[11:4] == ddc_pkg::REG_ROW0[11:4] && haddr[1:0] == 2'h0) begin
        rd_v[ddc_pkg::A_W-1:0] = row_q[haddr[3:2]];
      end
    end
  end

  // address phase capture; write data lands one edge later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_q <= hsel & htrans[1] & hwrite & (haddr[31:12] == 20'h00000);
        wr_addr_q <= haddr[11:0];
        if (hsel & htrans[1] & ~hwrite) begin
          hrdata <= rd_v;
        end
      end
    end
  end

  // configuration: software writes, mode commands from the link win
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= ddc_pkg::CFG_RST;
    end else if (cmd_ok && cmd == ddc_pkg::CMD_MRS && s_ba == ddc_pkg::MR_SEL) begin
      cfg_q <= cfg_fix({cfg_q[ddc_pkg::CFG_W-1:5], s_a[4:0]});
    end else if (cmd_ok && cmd == ddc_pkg::CMD_MRS && s_ba == ddc_pkg::EMR1_SEL) begin
      cfg_q <= cfg_fix({cfg_q[ddc_pkg::CF_X16], s_a[4:0], cfg_q[4:0]});
    end else if (wr_pend_q && wr_addr_q == ddc_pkg::REG_CFG) begin
      cfg_q <= cfg_fix(hwdata[ddc_pkg::CFG_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // banks and rows
  // ---------------------------------------------------------------

  // open and close rows; auto precharge closes at burst end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      open_q <= 4'h0;
      for (int i = 0; i < ddc_pkg::NBANK; i++) begin
        row_q[i] <= '0;
      end
    end else begin
      if (bst_end && ap_q) begin
        open_q[bank_q] <= 1'b0;
      end
      if (cmd_ok && cmd == ddc_pkg::CMD_ACT) begin
        open_q[s_ba] <= 1'b1;
        row_q[s_ba]  <= cfg_q[ddc_pkg::CF_X16] ? {1'b0, s_a[12:0]} : s_a;
      end else if (cmd_ok && cmd == ddc_pkg::CMD_PRE) begin
        if (lk.pins[ddc_pkg::P_AP]) begin
          open_q <= 4'h0;
        end else begin
          open_q[s_ba] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // power states
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_q <= ddc_pkg::PWR_ON;
    end else begin
      unique case (pwr_q)
        ddc_pkg::PWR_ON: begin
          if (lk.rise && !s_cke) begin
            if (|open_q) begin
              pwr_q <= ddc_pkg::PWR_APD;
            end else if (!lk.pins[ddc_pkg::P_CS] && cmd == ddc_pkg::CMD_REF) begin
              pwr_q <= ddc_pkg::PWR_SR;
            end else begin
              pwr_q <= ddc_pkg::PWR_PPD;
            end
          end
        end
        ddc_pkg::PWR_PPD, ddc_pkg::PWR_APD: begin
          if (lk.rise && s_cke) begin
            pwr_q <= ddc_pkg::PWR_ON;
          end
        end
        // the link clock may be stopped, so no crossing is awaited
        ddc_pkg::PWR_SR: begin
          if (s_cke) begin
            pwr_q <= ddc_pkg::PWR_ON;
          end
        end
      endcase
    end
  end

  // delay loop lock counter; self refresh stops the loop
  always_ff @(posedge sys_clk) begin
    if (rst || pwr_q == ddc_pkg::PWR_SR) begin
      lock_q <= 5'h00;
    end else if (lk.rise && lock_q != ddc_pkg::DLL_LOCK_RISES) begin
      lock_q <= lock_q + 5'h01;
    end
  end

  // refresh counter, and strobe history for write edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_q <= 16'h0000;
      dqs_q <= 1'b0;
    end else begin
      dqs_q <= lk.pins[ddc_pkg::P_DQS];
      if (cmd_ok && cmd == ddc_pkg::CMD_REF) begin
        ref_q <= ref_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // burst engine: one access in flight, a new one replaces it
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bst_q  <= ddc_pkg::BST_IDLE;
      lat_q  <= 4'h0;
      beat_q <= 3'h0;
      bank_q <= 2'h0;
      col_q  <= 4'h0;
      ap_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else if (col_cmd) begin
      bst_q  <= ddc_pkg::BST_WAIT;
      lat_q  <= (cmd == ddc_pkg::CMD_WR) ? rl - 4'h1 : rl;
      bank_q <= s_ba;
      col_q  <= s_a[3:0];
      ap_q   <= lk.pins[ddc_pkg::P_AP];
      wr_q   <= (cmd == ddc_pkg::CMD_WR);
    end else begin
      unique case (bst_q)
        ddc_pkg::BST_IDLE: ;
        ddc_pkg::BST_WAIT: begin
          if (lk.rise) begin
            if (lat_q == 4'h1) begin
              bst_q  <= wr_q ? ddc_pkg::BST_WR : ddc_pkg::BST_RD;
              beat_q <= 3'h0;
            end else begin
              lat_q <= lat_q - 4'h1;
            end
          end
        end
        ddc_pkg::BST_RD, ddc_pkg::BST_WR: begin
          if (bst_end) begin
            bst_q <= ddc_pkg::BST_IDLE;
          end else if (rd_step || wr_step) begin
            beat_q <= beat_q + 3'h1;
          end
        end
      endcase
    end
  end

  // column access fetch; all eight words are fetched at once on the read command
  always_ff @(posedge sys_clk) begin
    if (col_cmd && cmd == ddc_pkg::CMD_RD) begin
      for (int i = 0; i < 8; i++) begin
        pf_q[i] <= mem_q[{s_ba, bidx(s_a[3:0], 3'(i), cfg_q[ddc_pkg::CF_BL8],
                                     cfg_q[ddc_pkg::CF_BT])}];
      end
    end
  end

  // array write; only column words are kept, the row is not stored
  always_ff @(posedge sys_clk) begin
    if (wr_step && !lk.pins[ddc_pkg::P_DM]) begin
      mem_q[{bank_q, bidx(col_q, beat_q, cfg_q[ddc_pkg::CF_BL8],
                          cfg_q[ddc_pkg::CF_BT])}] <= lk.pins[ddc_pkg::P_DQ+:8];
    end
  end

  // ---------------------------------------------------------------
  // read drivers, termination and drive strength
  // ---------------------------------------------------------------

  // strobe is edge aligned: high after rising, low after falling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_out   <= 8'h00;
      dq_oe_n  <= 1'b1;
      dqs_out  <= 1'b0;
      dqs_oe_n <= 1'b1;
    end else if (pwr_q != ddc_pkg::PWR_ON) begin
      dq_oe_n  <= 1'b1;
      dqs_oe_n <= 1'b1;
    end else if (rd_start) begin
      dq_out   <= pf_q[0];
      dq_oe_n  <= 1'b0;
      dqs_out  <= 1'b1;
      dqs_oe_n <= 1'b0;
    end else if (rd_step && bst_end) begin
      dq_oe_n  <= 1'b1;
      dqs_out  <= 1'b0;
      dqs_oe_n <= 1'b1;
    end else if (rd_step) begin
      dq_out  <= pf_q[beat_q + 3'h1];
      dqs_out <= lk.rise;
    end else if (bst_q != ddc_pkg::BST_RD) begin
      dq_oe_n  <= 1'b1;
      dqs_oe_n <= 1'b1;
    end
  end

  // termination sampled at rising crossings; dead in self refresh
  always_ff @(posedge sys_clk) begin
    if (rst || pwr_q == ddc_pkg::PWR_SR) begin
      term_on <= 1'b0;
    end else if (lk.rise) begin
      term_on <= lk.pins[ddc_pkg::P_ODT] & ~cfg_q[ddc_pkg::CF_ODTOFF];
    end
  end

  // drive strength follows its configuration bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_reduced <= 1'b0;
    end else begin
      drive_reduced <= cfg_q[ddc_pkg::CF_DRVRED];
    end
  end

endmodule

//--- bench/ddc_assertions.sv
// checker: port-level burst, strobe and power rules
`timescale 1ns/10ps
module ddc_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       cke,
  input wire logic       termination_enable,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [7:0] dq_out,
  input wire logic       dq_oe_n,
  input wire logic       dqs_out,
  input wire logic       dqs_oe_n,
  input wire logic       term_on
);
  logic [5:0] run_q;

  // ----------------------------------------
  // drive length in cycles gives burst size
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || dq_oe_n) begin
      run_q <= 6'h0;
    end else begin
      run_q <= run_q + 6'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_oe_pair: assert property (dq_oe_n == dqs_oe_n) else $error("drivers differ");
  a_first_strobe: assert property ($fell(dq_oe_n) |-> dqs_out) else $error("first strobe low");
  a_data_edge: assert property (!dq_oe_n && !$past(dq_oe_n) && $changed(dq_out) |-> $changed(dqs_out))
    else $error("data moved off a crossing");
  a_strobe_space: assert property (!dqs_oe_n && $changed(dqs_out) |=> $stable(dqs_out) [*3])
    else $error("strobe spacing wrong");
  a_burst_len: assert property ($rose(dq_oe_n) |-> run_q inside {[15:17], [31:33]})
    else $error("burst length wrong");
  a_cke_off: assert property (!cke [*8] ##1 !cke [*8] |-> dq_oe_n) else $error("driving while off");
  a_term_rose: assert property ($rose(term_on) |-> $past(termination_enable, 3))
    else $error("termination without enable");
endmodule

//--- bench/ddc_ctrl.sv
// partner model: memory controller driving the link pins
`timescale 1ns/10ps
module ddc_ctrl (
  output logic        ck,
  output logic        ck_n,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  bank_select_lines,
  output logic [13:0] addr,
  output logic        termination_enable,
  output logic        write_byte_mask,
  output logic        dqs_in,
  output logic [7:0]  dq_in
);
  // link clock runs free, phase unrelated to sys_clk
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
    {bank_select_lines, addr, termination_enable, write_byte_mask, dqs_in, dq_in} = 27'h0;
    ck = 1'b0;
    ck_n = 1'b1;
    #137;
    forever begin
      #400 ck = ~ck;
      ck_n = ~ck;
    end
  end

  // one command, stable across the whole rising crossing
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [13:0] a, input logic s);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = {s, c};
    bank_select_lines = b;
    addr = a;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_select_lines = ~b;
    addr = ~a; // released bus must not keep its value
  endtask

  // write words centred on strobe edges, wl rises after the command
  task automatic wr(input int wl, input int n, input logic [7:0] d [8], input logic [7:0] m);
    repeat (wl) @(posedge ck);
    #400;
    for (int i = 0; i < n; i++) begin
      dq_in = d[i];
      write_byte_mask = m[i];
      #200 dqs_in = ~dqs_in;
      #200;
    end
    dq_in = ~dq_in;
  endtask

  // only called between bursts, so enable stays high over accesses
  task automatic pwr(input logic v);
    @(negedge ck) cke = v;
  endtask
endmodule

//--- bench/tb.sv
// testbench: register and link traffic with queued expectations
`timescale 1ns/10ps
module tb;
  logic        sys_clk, rst, hwrite, hreadyout, hresp, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
  logic        termination_enable, write_byte_mask, dqs_in, dq_oe_n, dqs_out, dqs_oe_n, term_on, drive_reduced;
  logic        rph_q, pdqs_q, poe_q;
  logic [1:0]  htrans, bank_select_lines, b;
  logic [13:0] addr, row;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  dq_in, dq_out, d [8], e [8];
  logic [31:0] aq [$];
  logic [7:0]  dq [$];
  int          fail_count, num_checks, cyc, al;

  ddc_ctrl m (.ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_lines, .addr, .termination_enable,
              .write_byte_mask, .dqs_in, .dq_in);
  ddc_top dut (.sys_clk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
               .hreadyout, .hresp, .hrdata, .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_lines,
               .addr, .termination_enable, .write_byte_mask, .dqs_in, .dq_in, .dq_out, .dq_oe_n, .dqs_out,
               .dqs_oe_n, .term_on, .drive_reduced);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, x, s);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // bus master: hold each phase until ready
  // ----------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    aq.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask

  // read burst: words go to the queue, first-word rise count checked here
  task automatic rdb(input logic [13:0] c, input int rl, input int n, input logic [7:0] x [8]);
    int k;
    for (int i = 0; i < n; i++) dq.push_back(x[i]);
    m.cmd(ddc_pkg::CMD_RD, b, c, 1'b0);
    k = 0;
    do begin
      @(posedge ck);
      k++;
      #500;
    end while (dq_oe_n && k < 20);
    chk("latency", k, rl);
    repeat (n / 2 + 2) @(posedge ck);
  endtask

  // hold enable low over three rises, read the power state
  task automatic pd(input logic [31:0] x);
    m.pwr(1'b0);
    repeat (3) @(posedge ck);
    rd(32'h4, x);
    m.pwr(1'b1);
    repeat (2) @(posedge ck);
  endtask

  // monitor: one word per crossing while driving, one word per read phase
  always @(posedge sys_clk) begin
    rph_q <= !rst && htrans[1] && !hwrite;
    pdqs_q <= dqs_out;
    poe_q <= dq_oe_n;
    if (rph_q) chk("hrdata", hrdata, aq.pop_front());
    if (!dq_oe_n && (poe_q || dqs_out !== pdqs_q)) chk("dq_out", dq_out, dq.size() ? dq.pop_front() : 8'hxx);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    {rst, htrans, haddr, hwrite, hwdata} = {1'b1, 67'h0};
    {fail_count, num_checks, cyc} = 96'h0;
    void'($urandom(32'h3ec5));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(32'h0, 32'h00c);
    rd(32'h100, 32'h0);
    b = 2'($urandom);
    row = 14'($urandom);
    m.cmd(ddc_pkg::CMD_ACT, b, row, 1'b0);
    rd(32'h10 + 32'(b) * 4, {18'h0, row});
    foreach (d[i]) d[i] = 8'($urandom);
    foreach (e[i]) e[i] = 8'($urandom);
    m.cmd(ddc_pkg::CMD_WR, b, 14'h0, 1'b0);
    m.wr(2, 4, d, 8'h00);
    m.cmd(ddc_pkg::CMD_WR, b, 14'h0, 1'b0);
    m.wr(2, 4, e, 8'h04);
    e[2] = d[2];
    for (int cl = 3; cl <= 6; cl++) begin
      al = $urandom % 6;
      bus(1'b1, 32'h0, 32'(al * 32 + cl * 4));
      rdb(14'h0, al + cl, 4, e);
    end
    bus(1'b1, 32'h0, 32'h233); // bl8, interleaved, cl 4, al 1, reduced drive
    foreach (d[i]) d[i] = 8'($urandom);
    m.cmd(ddc_pkg::CMD_WR, b, 14'h0, 1'b0);
    m.wr(4, 8, d, 8'h00);
    foreach (e[i]) e[i] = d[i ^ 3];
    rdb(14'h3, 5, 8, e);
    chk("drive", drive_reduced, 32'h1);
    m.cmd(ddc_pkg::CMD_RD, b, 14'h0, 1'b1);
    repeat (12) @(posedge ck);
    m.cmd(ddc_pkg::CMD_MRS, 2'h0, 14'h00c, 1'b0);
    rd(32'h0, 32'h22c);
    @(negedge ck) m.termination_enable = 1'b1;
    repeat (2) @(posedge ck);
    #500 chk("term", term_on, 32'h1);
    m.cmd(ddc_pkg::CMD_MRS, 2'h1, 14'h018, 1'b0); // second mode select: termination off, reduced drive
    rd(32'h0, 32'h30c);
    @(posedge ck) #500 chk("term", term_on, 32'h0);
    pd(32'h60 | (32'h1 << b));
    m.cmd(ddc_pkg::CMD_PRE, 2'h0, 14'h400, 1'b0);
    pd(32'h50);
    m.cmd(ddc_pkg::CMD_REF, 2'h0, 14'h0, 1'b0);
    // refresh with enable low at the same crossing enters self refresh
    @(negedge ck) {m.cke, m.cs_n, m.ras_n, m.cas_n, m.we_n} = 5'h01;
    @(negedge ck) {m.cs_n, m.ras_n, m.cas_n, m.we_n} = 4'hf;
    rd(32'h4, 32'h0001_0030);
    m.pwr(1'b1);
    repeat (2) @(posedge ck);
    m.cmd(ddc_pkg::CMD_RD, b, 14'h0, 1'b0);
    repeat (12) @(posedge ck);
    chk("left", dq.size(), 32'h0);
    test_done();
  end
endmodule

bind ddc_top ddc_chk u_chk (.sys_clk, .rst, .cke, .termination_enable, .hreadyout, .hresp, .dq_out, .dq_oe_n,
                            .dqs_out, .dqs_oe_n, .term_on);
